//--- hdl/encoder_pkg.sv
// shared constants of the encoder position post-processing block
package encoder_pkg;
    // attribute numbers seen by the network controller
    localparam logic [7:0] ATTR_POSITION = 8'h03;
    localparam logic [7:0] ATTR_COUNT_SENSE = 8'h0C;
    localparam logic [7:0] ATTR_SCALE_EN = 8'h0E;
    localparam logic [7:0] ATTR_CUSTOM_CPT = 8'h10;
    localparam logic [7:0] ATTR_CUSTOM_RANGE = 8'h11;
    localparam logic [7:0] ATTR_PRESET = 8'h13;
    localparam logic [7:0] ATTR_SPEED = 8'h18;
    localparam logic [7:0] ATTR_SPEED_UNIT = 8'h19;
    localparam logic [7:0] ATTR_RUN_FLAGS = 8'h29;
    localparam logic [7:0] ATTR_HW_CPT = 8'h2A;
    localparam logic [7:0] ATTR_HW_TURNS = 8'h2B;
    localparam logic [7:0] ATTR_OFFSET = 8'h33;
    localparam logic [7:0] ATTR_COMMAND = 8'h68;
    // bit positions
    localparam int CMD_APPLY_BIT = 0;
    localparam int FLAG_DIR_BIT = 0;
    localparam int FLAG_SCALE_BIT = 1;
    // speed unit codes
    typedef enum logic [15:0] {
        UNIT_CPS = 16'h1F04,
        UNIT_CPMS = 16'h1F05,
        UNIT_CPM = 16'h1F07,
        UNIT_RPS = 16'h1F0E,
        UNIT_RPM = 16'h1F0F,
        UNIT_RPH = 16'h1F10
    } speed_unit_e;
    // reset values
    localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
    localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
    localparam logic SENSE_RESET = 1'h0;
    localparam logic SCALE_RESET = 1'h1;
    // per variant: 0 = 13-bit multiturn, 1 = 18-bit single, 2 = 16-bit multi
    localparam logic [31:0] HW_CPT_V0 = 32'h0000_2000;
    localparam logic [31:0] HW_CPT_V1 = 32'h0004_0000;
    localparam logic [31:0] HW_CPT_V2 = 32'h0001_0000;
    localparam logic [4:0] CPT_SHIFT_V0 = 5'h0D;
    localparam logic [4:0] CPT_SHIFT_V1 = 5'h12;
    localparam logic [4:0] CPT_SHIFT_V2 = 5'h10;
    localparam logic [15:0] HW_TURNS_MULTI = 16'h4000;
    localparam logic [15:0] HW_TURNS_SINGLE = 16'h0001;
    // widths
    localparam int RAW_W = 30;
    localparam int POS_W = 32;
    localparam int SPD_W = 48;
    // speed window timing
    localparam int CLK_HZ = 25_000_000;
    localparam int SPEED_WINDOW_MS = 100;
    localparam int SPEED_WINDOW_CYC = CLK_HZ / 1000 * SPEED_WINDOW_MS;
    // unit conversion factors over one window
    localparam logic [15:0] FAC_X10 = 16'h000A;
    localparam logic [15:0] FAC_X600 = 16'h0258;
    localparam logic [15:0] FAC_X36000 = 16'h8CA0;
    localparam logic [15:0] FAC_X1 = 16'h0001;
    localparam logic [15:0] DIV_CPMS = 16'h0064;
    localparam int RPH_STEP_BITS = 2;
endpackage

//--- hdl/encoder_position.sv
// position preset, scaling, speed and status for an absolute encoder
`timescale 1ns/100ps
module encoder_position #(
    parameter int VARIANT = 2,
    parameter int SPEED_WINDOW_CYC = encoder_pkg::SPEED_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [encoder_pkg::RAW_W-1:0] rawPosition,
    input wire logic [7:0] attrAddr,
    input wire logic attrWrite,
    input wire logic attrRead,
    input wire logic [31:0] attrWrData,
    output logic [31:0] attrRdData,
    output logic attrRdValid,
    output logic [31:0] positionOut
);
    import encoder_pkg::*;

    // variant figures, fixed at build time
    localparam logic [31:0] HW_CPT = (VARIANT == 0) ? HW_CPT_V0 :
        (VARIANT == 1) ? HW_CPT_V1 : HW_CPT_V2;
    localparam logic [4:0] CPT_SHIFT = (VARIANT == 0) ? CPT_SHIFT_V0 :
        (VARIANT == 1) ? CPT_SHIFT_V1 : CPT_SHIFT_V2;
    localparam logic [15:0] HW_TURNS = (VARIANT == 1) ? HW_TURNS_SINGLE :
        HW_TURNS_MULTI;
    localparam logic [31:0] HW_TOTAL = HW_CPT * {16'h0000, HW_TURNS};

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_LAUNCH = 2'b01,
        SP_WAIT = 2'b11,
        SP_LOAD = 2'b10
    } speed_state_e;

    // configuration held for the controller
    logic [31:0] presetReg; // preset value
    logic [31:0] offsetReg; // position captured at preset
    logic senseReg; // 0 counts up clockwise
    logic scaleEnReg; // custom resolution on
    logic [31:0] customCptReg; // custom counts per turn
    logic [31:0] customRangeReg; // custom total range
    speed_unit_e unitReg; // speed unit selector
    // position path
    logic [31:0] readPosReg; // physical or scaled read position
    logic [31:0] prevPosReg; // read position one cycle back
    logic dirReg; // 1 while counting down
    logic [31:0] posOutReg;
    // speed path
    speed_state_e spStateReg;
    speed_state_e spStateNext;
    logic [31:0] lastPosReg; // output at previous window edge
    logic [31:0] deltaReg; // signed change over window
    logic [31:0] speedReg;
    // read port
    logic [31:0] rdDataReg;
    logic rdValidReg;
    logic [31:0] rdNext;

    // physical position after count sense
    wire [31:0] rawWide = {{(32 - RAW_W){1'b0}}, rawPosition};
    wire [31:0] sensePos = senseReg ? (HW_TOTAL - 32'h1 - rawWide) :
        rawWide;
    // custom ratio over physical per turn, the shift divides exactly
    wire [63:0] scaleProd = customCptReg * sensePos;
    wire [31:0] scaleShift = 32'(scaleProd >> CPT_SHIFT);

    // modulo by custom range wraps the scaled count
    wire posBusy;
    wire posDone;
    wire [31:0] posRem;
    serial_divider #(.W(POS_W)) posDiv (
        .clk(clk),
        .arst_n(arst_n),
        .start(scaleEnReg & ~posBusy),
        .dividend(scaleShift),
        .divisor(customRangeReg),
        .busy(posBusy),
        .done(posDone),
        .quotient(),
        .remainder(posRem)
    );

    // write decode
    wire wrSense = attrWrite && (attrAddr == ATTR_COUNT_SENSE);
    wire wrScale = attrWrite && (attrAddr == ATTR_SCALE_EN);
    wire wrCpt = attrWrite && (attrAddr == ATTR_CUSTOM_CPT);
    wire wrRange = attrWrite && (attrAddr == ATTR_CUSTOM_RANGE);
    wire wrPreset = attrWrite && (attrAddr == ATTR_PRESET);
    wire wrUnit = attrWrite && (attrAddr == ATTR_SPEED_UNIT);
    wire cmdApply = attrWrite && (attrAddr == ATTR_COMMAND) &&
        attrWrData[CMD_APPLY_BIT];
    // preset ceiling depends on scaling mode
    wire [31:0] presetMax = scaleEnReg ? (customRangeReg - 32'h1) :
        (HW_TOTAL - 32'h1);
    wire presetOk = (attrWrData <= presetMax);
    wire unitOk = (attrWrData[15:0] == UNIT_CPS) ||
        (attrWrData[15:0] == UNIT_CPMS) || (attrWrData[15:0] == UNIT_CPM) ||
        (attrWrData[15:0] == UNIT_RPS) || (attrWrData[15:0] == UNIT_RPM) ||
        (attrWrData[15:0] == UNIT_RPH);
    // out of range custom values fall back to the physical figures
    wire [31:0] cptIn = (attrWrData == 32'h0 || attrWrData > HW_CPT) ?
        HW_CPT : attrWrData;
    wire [31:0] rangeIn = (attrWrData == 32'h0 || attrWrData > HW_TOTAL) ?
        HW_TOTAL : attrWrData;

    // configuration registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            senseReg <= SENSE_RESET;
            scaleEnReg <= SCALE_RESET;
            customCptReg <= HW_CPT;
            customRangeReg <= HW_TOTAL;
            unitReg <= UNIT_CPS;
        end else begin
            if (wrSense)
                senseReg <= attrWrData[0];
            if (wrScale)
                scaleEnReg <= attrWrData[0];
            if (wrCpt)
                customCptReg <= cptIn;
            if (wrRange)
                customRangeReg <= rangeIn;
            // illegal codes are dropped, the old unit stays
            if (wrUnit && unitOk)
                unitReg <= speed_unit_e'(attrWrData[15:0]);
        end
    end

    // preset and offset; an over-limit preset is refused whole
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            presetReg <= PRESET_RESET;
            offsetReg <= OFFSET_RESET;
        end else if (wrPreset && presetOk) begin
            presetReg <= attrWrData;
            offsetReg <= readPosReg;
        end else if (cmdApply) begin
            offsetReg <= readPosReg;
        end
    end

    // read position: live physical, or scaled once per divide
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            readPosReg <= '0;
        else if (!scaleEnReg)
            readPosReg <= sensePos;
        else if (posDone)
            readPosReg <= posRem;
    end

    // output position and live direction; wraps are not filtered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            posOutReg <= '0;
            prevPosReg <= '0;
            dirReg <= 1'b0;
        end else begin
            posOutReg <= readPosReg + presetReg - offsetReg;
            prevPosReg <= readPosReg;
            if (readPosReg != prevPosReg)
                dirReg <= (readPosReg < prevPosReg);
        end
    end

    // window edge enable
    wire winTick;
    window_tick #(.PERIOD(SPEED_WINDOW_CYC)) winGen (
        .clk(clk),
        .arst_n(arst_n),
        .tick(winTick)
    );

    // unit conversion: magnitude times factor over divisor
    wire deltaNeg = deltaReg[31];
    wire [31:0] deltaMag = deltaNeg ? (32'h0 - deltaReg) : deltaReg;
    wire [31:0] effCpt = scaleEnReg ? customCptReg : HW_CPT;
    wire revUnit = (unitReg == UNIT_RPS) || (unitReg == UNIT_RPM) ||
        (unitReg == UNIT_RPH);
    wire [15:0] factor = (unitReg == UNIT_CPMS) ? FAC_X1 :
        (unitReg == UNIT_CPM || unitReg == UNIT_RPM) ? FAC_X600 :
        (unitReg == UNIT_RPH) ? FAC_X36000 : FAC_X10;
    wire [SPD_W-1:0] spdDividend = SPD_W'(deltaMag) * SPD_W'(factor);
    wire [SPD_W-1:0] spdDivisor = revUnit ? SPD_W'(effCpt) :
        (unitReg == UNIT_CPMS) ? SPD_W'(DIV_CPMS) : SPD_W'(FAC_X1);
    wire spdBusy;
    wire spdDone;
    wire [SPD_W-1:0] spdQuo;
    serial_divider #(.W(SPD_W)) spdDiv (
        .clk(clk),
        .arst_n(arst_n),
        .start(spStateReg == SP_LAUNCH),
        .dividend(spdDividend),
        .divisor(spdDivisor),
        .busy(spdBusy),
        .done(spdDone),
        .quotient(spdQuo),
        .remainder()
    );
    // rph keeps whole steps of four, the others keep the truncated quotient
    wire [31:0] spdMagQ = (unitReg == UNIT_RPH) ?
        {spdQuo[31:RPH_STEP_BITS], {RPH_STEP_BITS{1'b0}}} : spdQuo[31:0];
    wire [31:0] spdSigned = deltaNeg ? (32'h0 - spdMagQ) : spdMagQ;

    // speed sequencer, one pass per window
    always_comb begin
        spStateNext = spStateReg;
        case (spStateReg)
            SP_IDLE: begin
                if (winTick)
                    spStateNext = SP_LAUNCH;
            end
            SP_LAUNCH: begin
                spStateNext = SP_WAIT;
            end
            SP_WAIT: begin
                if (spdDone)
                    spStateNext = SP_LOAD;
            end
            default: begin
                spStateNext = SP_IDLE;
            end
        endcase
    end

    // window difference and speed result
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            spStateReg <= SP_IDLE;
            lastPosReg <= '0;
            deltaReg <= '0;
            speedReg <= '0;
        end else begin
            spStateReg <= spStateNext;
            if (spStateReg == SP_IDLE && winTick) begin
                deltaReg <= posOutReg - lastPosReg;
                lastPosReg <= posOutReg;
            end
            if (spStateReg == SP_LOAD)
                speedReg <= spdSigned;
        end
    end

    // read mux, unmapped attributes read zero
    always_comb begin
        if (attrAddr == ATTR_POSITION)
            rdNext = posOutReg;
        else if (attrAddr == ATTR_COUNT_SENSE)
            rdNext = {31'h0, senseReg};
        else if (attrAddr == ATTR_SCALE_EN)
            rdNext = {31'h0, scaleEnReg};
        else if (attrAddr == ATTR_CUSTOM_CPT)
            rdNext = customCptReg;
        else if (attrAddr == ATTR_CUSTOM_RANGE)
            rdNext = customRangeReg;
        else if (attrAddr == ATTR_PRESET)
            rdNext = presetReg;
        else if (attrAddr == ATTR_SPEED)
            rdNext = speedReg;
        else if (attrAddr == ATTR_SPEED_UNIT)
            rdNext = {16'h0, unitReg};
        else if (attrAddr == ATTR_RUN_FLAGS)
            rdNext = {30'h0, scaleEnReg, dirReg};
        else if (attrAddr == ATTR_HW_CPT)
            rdNext = HW_CPT;
        else if (attrAddr == ATTR_HW_TURNS)
            rdNext = {16'h0, HW_TURNS};
        else if (attrAddr == ATTR_OFFSET)
            rdNext = offsetReg;
        else
            rdNext = 32'h0;
    end

    // read answer one cycle after the request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdDataReg <= '0;
            rdValidReg <= 1'b0;
        end else begin
            rdValidReg <= attrRead;
            if (attrRead)
                rdDataReg <= rdNext;
        end
    end

    assign attrRdData = rdDataReg;
    assign attrRdValid = rdValidReg;
    assign positionOut = posOutReg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_preset_capture: assert property (
        wrPreset && presetOk |=> offsetReg == $past(readPosReg) &&
        presetReg == $past(attrWrData))
        else $error("preset write did not capture position");
    chk_preset_output: assert property (
        wrPreset && presetOk ##1 readPosReg == $past(readPosReg)
        |=> positionOut == presetReg)
        else $error("output not equal to preset after write");
    chk_preset_refused: assert property (
        wrPreset && !presetOk |=> $stable(presetReg) && $stable(offsetReg))
        else $error("over-limit preset was accepted");
    chk_apply_keeps: assert property (
        cmdApply && !wrPreset |=> offsetReg == $past(readPosReg) &&
        $stable(presetReg))
        else $error("apply command misbehaved");
    chk_unit_legal: assert property (
        unitReg inside {UNIT_CPS, UNIT_CPMS, UNIT_CPM, UNIT_RPS, UNIT_RPM,
        UNIT_RPH})
        else $error("speed unit holds an illegal code");
    chk_flags_read: assert property (
        attrRead && attrAddr == ATTR_RUN_FLAGS |=> attrRdValid &&
        attrRdData[31:2] == 30'h0 && attrRdData[1] == $past(scaleEnReg) &&
        attrRdData[0] == $past(dirReg))
        else $error("status byte read wrong");
    chk_speed_period: assert property (
        spStateReg == SP_IDLE && winTick |-> ##[3:60] spStateReg == SP_LOAD)
        else $error("speed not recomputed after window");
    chk_rph_step: assert property (
        spStateReg == SP_LOAD && unitReg == UNIT_RPH && !deltaNeg
        |=> speedReg[1:0] == 2'b00)
        else $error("rph speed not on step of four");
    chk_direction: assert property (
        readPosReg != prevPosReg |=>
        dirReg == ($past(readPosReg) < $past(prevPosReg)))
        else $error("direction flag disagrees with count");
    chk_physical_path: assert property (
        !scaleEnReg |=> readPosReg == $past(sensePos))
        else $error("physical read position not followed");

    cov_preset_write: cover property (wrPreset && presetOk);
    cov_apply_cmd: cover property (cmdApply);
    cov_speed_neg: cover property (spStateReg == SP_LOAD && deltaNeg);
    cov_rph_load: cover property (spStateReg == SP_LOAD &&
        unitReg == UNIT_RPH);
endmodule

//--- hdl/serial_divider.sv
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/100ps
module serial_divider #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [W-1:0] quotient,
    output logic [W-1:0] remainder
);
    logic [W:0] remReg; // partial remainder
    logic [W-1:0] quoReg; // dividend shifts out, quotient in
    logic [W-1:0] dsrReg; // held divisor
    logic [7:0] cntReg; // bits still to do
    logic doneReg;
    wire [W:0] shifted = {remReg[W-1:0], quoReg[W-1]};
    wire [W:0] trial = shifted - {1'b0, dsrReg};
    wire fits = ~trial[W];

    // a start while busy is ignored, the caller waits for done
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            remReg <= '0;
            quoReg <= '0;
            dsrReg <= '0;
            cntReg <= '0;
            doneReg <= 1'b0;
        end else if (start && cntReg == '0) begin
            remReg <= '0;
            quoReg <= dividend;
            dsrReg <= divisor;
            cntReg <= 8'(W);
            doneReg <= 1'b0;
        end else if (cntReg != '0) begin
            remReg <= fits ? trial : shifted;
            quoReg <= {quoReg[W-2:0], fits};
            cntReg <= cntReg - 8'h01;
            doneReg <= (cntReg == 8'h01);
        end else begin
            doneReg <= 1'b0;
        end
    end

    assign busy = (cntReg != '0);
    assign done = doneReg;
    assign quotient = quoReg;
    assign remainder = remReg[W-1:0];
endmodule

//--- hdl/window_tick.sv
// divider giving a one-cycle enable every PERIOD clocks
`timescale 1ns/100ps
module window_tick #(
    parameter int PERIOD = 1000
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic tick
);
    logic [31:0] cntReg; // cycles into current window
    logic tickReg;
    wire lastCyc = (cntReg == 32'(PERIOD - 1));

    // free running, so the window never drifts with bus traffic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cntReg <= '0;
            tickReg <= 1'b0;
        end else begin
            cntReg <= lastCyc ? '0 : cntReg + 32'h1;
            tickReg <= lastCyc;
        end
    end

    assign tick = tickReg;
endmodule

//--- tb/attr_host.sv
// controller-side model issuing attribute reads and writes
`timescale 1ns/100ps
module attr_host (
    input wire logic clk,
    output logic [7:0] attrAddr,
    output logic attrWrite,
    output logic attrRead,
    output logic [31:0] attrWrData,
    input wire logic [31:0] attrRdData,
    input wire logic attrRdValid
);
    // idle bus at time zero, no strobe raised
    initial begin
        attrAddr = 8'h00;
        attrWrite = 1'b0;
        attrRead = 1'b0;
        attrWrData = 32'h0000_0000;
    end
    // one-cycle write; released lines are inverted so stale data never
    // happens to look like the value just written
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        attrAddr <= a;
        attrWrData <= d;
        attrWrite <= 1'b1;
        @(posedge clk);
        attrWrite <= 1'b0;
        attrAddr <= ~a;
        attrWrData <= ~d;
    endtask
    // one-cycle read; answer awaited for a bounded number of edges
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        d = 'x;
        @(posedge clk);
        attrAddr <= a;
        attrRead <= 1'b1;
        @(posedge clk);
        attrRead <= 1'b0;
        attrAddr <= ~a;
        repeat (4) begin
            @(posedge clk);
            if (attrRdValid === 1'b1) begin
                d = attrRdData;
                break;
            end
        end
    endtask
endmodule

//--- tb/encoder_position_tb.sv
// self-checking bench for the encoder position block
`timescale 1ns/100ps
module encoder_position_tb;
    import encoder_pkg::*;
    localparam int WIN = 200; // short speed window keeps the run brief
    localparam longint TOTAL = 64'h4000_0000;
    localparam longint CPT = 64'h1_0000;
    localparam longint STEP = 64'h3E8; // counts per clock while ramping
    localparam longint D = WIN * STEP; // position change per window
    // expected speed per unit slot, steady shaft, physical resolution
    function automatic longint spdExp(input int i);
        case (i)
            0: return D * 10;
            1: return D / 100;
            2: return D * 600;
            3: return D * 10 / CPT;
            4: return D * 600 / CPT;
            default: return (D * 36000 / CPT) & ~64'h3;
        endcase
    endfunction
    // unit code per slot, same order as the speed table
    function automatic logic [31:0] unitCode(input int i);
        case (i)
            0: return 32'(UNIT_CPS);
            1: return 32'(UNIT_CPMS);
            2: return 32'(UNIT_CPM);
            3: return 32'(UNIT_RPS);
            4: return 32'(UNIT_RPM);
            default: return 32'(UNIT_RPH);
        endcase
    endfunction
    logic clk, arst_n, ramp, attrWrite, attrRead, attrRdValid;
    logic [RAW_W-1:0] rawPosition;
    logic [7:0] attrAddr;
    logic [31:0] attrWrData, attrRdData, positionOut, rdv, seed;
    int n_mismatch, checks;
    // reference state of the bench model
    longint mPreset, mOffset, mCpt, mRange;
    int mSense, mScale;

    encoder_position #(.VARIANT(2), .SPEED_WINDOW_CYC(WIN))
        encoder_position_i (
        .clk(clk), .arst_n(arst_n), .rawPosition(rawPosition),
        .attrAddr(attrAddr), .attrWrite(attrWrite), .attrRead(attrRead),
        .attrWrData(attrWrData), .attrRdData(attrRdData),
        .attrRdValid(attrRdValid), .positionOut(positionOut));
    attr_host attr_host_i (
        .clk(clk), .attrAddr(attrAddr), .attrWrite(attrWrite),
        .attrRead(attrRead), .attrWrData(attrWrData),
        .attrRdData(attrRdData), .attrRdValid(attrRdValid));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // shaft turning at constant speed for the speed scenarios
    always @(posedge clk) if (ramp) rawPosition <= rawPosition + 30'(STEP);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // read position as the model sees it: sense first, then scaling
    function automatic longint readPos(input longint raw);
        longint sp;
        sp = mSense ? TOTAL - 1 - raw : raw;
        return mScale ? ((mCpt * sp) >> 16) % mRange : sp;
    endfunction
    function automatic logic [31:0] expPos();
        return 32'(readPos(rawPosition) + mPreset - mOffset);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // land just after an edge so registered outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic setRaw(input longint v);
        @(posedge clk);
        rawPosition <= 30'(v);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        attr_host_i.rd(a, rdv);
        check(rdv, exp);
    endtask
    // write through the host and mirror it; only the device's preset limit is modelled
    task automatic mwr(input logic [7:0] a, input longint d);
        attr_host_i.wr(a, 32'(d));
        case (a)
            ATTR_SCALE_EN: mScale = int'(d & 1);
            ATTR_COUNT_SENSE: mSense = int'(d & 1);
            ATTR_CUSTOM_CPT: mCpt = d;
            ATTR_CUSTOM_RANGE: mRange = d;
            ATTR_PRESET: if (d <= (mScale ? mRange : TOTAL) - 1) begin
                mPreset = d;
                mOffset = readPos(rawPosition);
            end
            ATTR_COMMAND: if (d & 1) mOffset = readPos(rawPosition);
            default: ;
        endcase
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang counts as a failure
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        arst_n = 1'b0;
        rawPosition = '0;
        ramp = 1'b0;
        seed = 32'hE017;
        n_mismatch = 0;
        checks = 0;
        {mPreset, mOffset, mSense, mScale, mCpt, mRange} = {64'h0, 64'h0,
            32'h0, 32'h1, CPT, TOTAL};
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        settle(40);
        // reset values and fixed resolution figures
        check(positionOut, expPos());
        rdc(ATTR_PRESET, 32'h0000_0000);
        rdc(ATTR_OFFSET, 32'h0000_0000);
        rdc(ATTR_SPEED_UNIT, 32'h0000_1F04);
        rdc(ATTR_RUN_FLAGS, 32'h0000_0002);
        rdc(ATTR_HW_CPT, 32'(CPT));
        rdc(ATTR_HW_TURNS, 32'h0000_4000);
        // physical resolution, random shaft positions
        mwr(ATTR_SCALE_EN, 0);
        repeat (4) begin
            seed = lfsr(lfsr(seed));
            setRaw(seed[29:0]);
            settle(3);
            check(positionOut, expPos());
        end
        // preset bound to the standing shaft, then motion follows it
        setRaw(64'h3E8);
        mwr(ATTR_PRESET, 64'h32);
        settle(2);
        check(positionOut, 32'h0000_0032);
        setRaw(64'h3E9);
        settle(3);
        check(positionOut, 32'h0000_0033);
        rdc(ATTR_OFFSET, 32'h0000_03E8);
        // re-apply stored preset at another place
        setRaw(64'h7D0);
        mwr(ATTR_COMMAND, 1);
        settle(2);
        check(positionOut, 32'h0000_0032);
        // unscaled limit is total counts minus one
        mwr(ATTR_PRESET, TOTAL);
        rdc(ATTR_PRESET, 32'(mPreset));
        mwr(ATTR_PRESET, TOTAL - 1);
        rdc(ATTR_PRESET, 32'(mPreset));
        settle(2);
        check(positionOut, expPos());
        // counting direction under both count senses
        for (int s = 0; s < 2; s++) begin
            mwr(ATTR_COUNT_SENSE, s);
            setRaw(64'hBB8);
            settle(3);
            setRaw(64'hBBD);
            settle(3);
            rdc(ATTR_RUN_FLAGS, 32'(s));
            check(positionOut, expPos());
            setRaw(64'hBAE);
            settle(3);
            rdc(ATTR_RUN_FLAGS, 32'(1 - s));
        end
        // custom resolution of powers of two, preset done again after it
        mwr(ATTR_COUNT_SENSE, 0);
        mwr(ATTR_SCALE_EN, 1);
        mwr(ATTR_CUSTOM_CPT, 64'h800);
        mwr(ATTR_CUSTOM_RANGE, 64'h20_0000);
        // a divide in flight ends on old figures, the next one on new
        settle(80);
        mwr(ATTR_PRESET, 64'h20_0000);
        rdc(ATTR_PRESET, 32'(mPreset));
        mwr(ATTR_PRESET, 64'h1F_FFFF);
        settle(40);
        check(positionOut, 32'h001F_FFFF);
        setRaw(rawPosition + 64'h3_0000);
        settle(80);
        check(positionOut, expPos());
        rdc(ATTR_POSITION, expPos());
        rdc(ATTR_CUSTOM_CPT, 32'(mCpt));
        rdc(ATTR_RUN_FLAGS, 32'h0000_0002);
        // speed in every unit while the shaft turns steadily
        mwr(ATTR_SCALE_EN, 0);
        ramp = 1'b1;
        for (int i = 0; i < 6; i++) begin
            mwr(ATTR_SPEED_UNIT, unitCode(i));
            rdc(ATTR_SPEED_UNIT, unitCode(i));
            settle(3 * WIN);
            rdc(ATTR_SPEED, 32'(spdExp(i)));
        end
        // a code outside the list leaves the unit alone
        mwr(ATTR_SPEED_UNIT, 64'h1F06);
        rdc(ATTR_SPEED_UNIT, 32'h0000_1F10);
        ramp = 1'b0;
        summarize();
    end
endmodule
